// [tb/testbench.sv]
// self-checking bench for the overlay timing sequencer
`timescale 1ns/1ps
module testbench;
  import vot_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic reset, hsel, hwrite, under, fault, gate, hrdy, hresp, fe, pclk, ce;
  logic [31:0] haddr, hwdata, hrdata, fbase, bg, fa, fb;
  logic [1:0] htrans, ls, vx, fx, bx, ds;
  logic [2:0] hsize;
  logic [31:0] prog [0:19];
  logic [31:0] q [$];
  int errors = 0, cmp_count = 0, idx = 0, fe_n = 0, v;
  bit chk_on = 1'b0, blank_m = 1'b0;
  logic [31:0] exp_w;

  always #2 clk = ~clk;

  vot_timing_seq u_dut (
    .clk, .reset, .ce(ce), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hrdy), .hreadyout(hrdy), .hresp, .hrdata,
    .pixel_clk_in(pclk), .fifo_underrun(under), .bus_fault(fault),
    .line_sync_out(ls), .vertical_out(vx), .field_select_out(fx),
    .blank_out(bx), .data_strobe_ctl(ds), .frame_end(fe),
    .fetch_base_out(fbase), .background_out(bg));
  vot_pix_gate u_gate (.run(gate), .pclk);

  // ------------------------------------------------------------
  // tasks and model
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk("register", r, e);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] tw(input int a, v, f, b, d, c, p, l);
    return 32'((l << W_LAST) | (p << W_LOOP) | (c << W_CNT)
      | (d << W_DS) | (b << W_BX) | (f << W_FX) | (v << W_VX) | a);
  endfunction

  task automatic setup();
    for (int i = 0; i < 20; i++) wr(12'h400 + 12'(i * 4), prog[i]);
    wr(OFF_CMD, 32'h0);
    wr(OFF_BG, 32'h80108010);
    wr(OFF_FC0, 32'h0780505A);
    wr(OFF_FA0, fa);
    wr(OFF_FB0, fb);
    wr(OFF_CONFIG, 32'h2042);
    wr(12'h404, 32'hFFFFFFFF);
    wr(12'h500, prog[0]);
  endtask

  // runs the gate until the model has seen pixel n
  task automatic run(input int n);
    int k = 0;
    gate <= 1'b1;
    chk_on = 1'b1;
    while (idx < n && k < 20000) begin
      @(posedge clk);
      k++;
    end
    gate <= 1'b0;
    chk_on = 1'b0;
    chk("pixels", idx, n);
    if (idx < n) stop_test();
  endtask

  always @(negedge pclk) if (chk_on) begin
    exp_w = q[idx];
    // blanking forces the remote source and idles the strobe
    if (blank_m) begin
      exp_w[9:8] = PAIR_IDLE;
      exp_w[5:4] = SEL_REMOTE;
    end
    chk("pairs", {ds, bx, fx, vx, ls}, exp_w[9:0]);
    chk("base", fbase, q[idx][3:2] == 2'h3 ? fb : fa);
    chk("colour", bg, 32'h80108010);
    idx++;
  end

  always @(posedge clk) if (fe === 1'b1) fe_n++;

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset <= 1'b1;
    {hsel, hwrite, under, fault, gate} <= '0;
    ce <= 1'b1;
    {haddr, hwdata, htrans} <= '0;
    hsize <= HSIZE_WORD;
    fa = lfsr(32'hBAE7);
    fb = lfsr(fa);
    for (int b = 0; b < 20; b += 5) begin
      v = b / 10 * 3;
      prog[b] = tw(0, v, 3, 0, 1, b % 10 ? 1 : 2, 1, 0);
      prog[b + 1] = tw(0, v, 3, 0, 1, 3, 0, 0);
      prog[b + 2] = tw(3, v, 3, 3, 1, 1, 0, 0);
      prog[b + 3] = tw(3, v, b % 10 ? 0 : 3, 3, 0, 4, 0, 0);
      prog[b + 4] = tw(3, v, 3, 0, 1, 2, 1, b == 15);
    end
    // three frames: loops expand to their repeat counts
    for (int r = 0; r < 3; r++)
      for (int b = 0; b < 20; b += 5)
        repeat (prog[b][22:11])
          for (int e = b + 1; e < b + 5; e++)
            repeat (prog[e][22:11]) q.push_back(prog[e]);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) rd(12'(i * 4), RST_REG);
    rd(12'h040, 32'h0);
    setup();
    rd(OFF_CONFIG, 32'h2042);
    rd(OFF_FC0, 32'h0780505A);
    rd(OFF_FB0, fb);
    rd(OFF_FC1, RST_REG);
    rd(12'h404, prog[1]);
    rd(12'h500, prog[0]);
    // a fault while the clock enable is low must leave no trace
    ce <= 1'b0;
    fault <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    fault <= 1'b0;
    rd(OFF_EVENT, 32'h0);
    under <= 1'b1;
    @(posedge clk);
    under <= 1'b0;
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    rd(OFF_EVENT, 32'h3);
    wr(OFF_EVENT, 32'h3);
    rd(OFF_EVENT, 32'h0);
    run(121);
    chk("frames", fe_n, 2);
    rd(OFF_EVENT, 32'h4);
    run(148);
    // stopped on an entry boundary, so blanking starts with the next entry
    wr(OFF_CMD, 32'h4);
    blank_m = 1'b1;
    run(150);
    blank_m = 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFF_CONFIG, RST_REG);
    idx = 0;
    setup();
    run(15);
    stop_test();
  end
endmodule

// [tb/vot_asserts.sv]
// port checker for the overlay timing sequencer
`timescale 1ns/1ps
module vot_asserts
  import vot_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pixel_clk_in,
  input wire logic [1:0] line_sync_out,
  input wire logic [1:0] vertical_out,
  input wire logic [1:0] field_select_out,
  input wire logic [1:0] data_strobe_ctl,
  input wire logic frame_end
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_rst_idle;
    disable iff (1'b0) reset |=> field_select_out == SEL_REMOTE
      && line_sync_out == PAIR_IDLE && !frame_end;
  endproperty
  property p_read_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_gfx_active;
    field_select_out == SEL_GFX |-> data_strobe_ctl == 2'h0
      && line_sync_out == 2'h3;
  endproperty
  property p_vert_pair;
    vertical_out == PAIR_IDLE || vertical_out == 2'h3;
  endproperty
  // sync may only end after the closing entry, which strobes 01
  property p_sync_close;
    $fell(line_sync_out[0]) |-> $past(data_strobe_ctl) == 2'h1;
  endproperty
  property p_frame_pulse;
    frame_end |=> (!frame_end) [*8];
  endproperty
  // a parked pixel clock must freeze the sequence
  property p_pix_quiet;
    (!pixel_clk_in) [*8] |-> $stable(line_sync_out)
      && $stable(vertical_out);
  endproperty

  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs not idle after reset");
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  a_okay: assert property (p_okay)
    else $error("bus response not okay");
  a_gfx_active: assert property (p_gfx_active)
    else $error("graphics selected outside active data");
  a_vert_pair: assert property (p_vert_pair)
    else $error("vertical pair not a field code");
  a_sync_close: assert property (p_sync_close)
    else $error("line sync ended outside closing entry");
  a_frame_pulse: assert property (p_frame_pulse)
    else $error("frame end pulse too long");
  a_pix_quiet: assert property (p_pix_quiet)
    else $error("outputs moved without pixel clock");

  c_frame: cover property (frame_end);
  c_gfx: cover property (field_select_out == SEL_GFX);
  c_read: cover property (!hreadyout);
endmodule

bind vot_timing_seq vot_asserts u_chk (
  .clk, .reset, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .pixel_clk_in, .line_sync_out, .vertical_out, .field_select_out,
  .data_strobe_ctl, .frame_end);

// [tb/vot_pix_gate.sv]
// gated pixel clock as the outside gating logic delivers it
`timescale 1ns/1ps
module vot_pix_gate (
  input wire logic run,
  output logic pclk
);
  initial pclk = 1'b0;
  // passes pulses only while open, parks low whenever run is low, mid-frame included
  always begin
    wait (run);
    #1.3 pclk = 1'b1;
    #62.5 pclk = 1'b0;
    #61.2;
  end
endmodule

// [verilog/vot_edge_sync.sv]
// two-stage synchroniser with edge detection for an outside level
`timescale 1ns/1ps
module vot_edge_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } vot_sync_t;

  vot_sync_t r;
  vot_sync_t n;

  always_comb begin
    n = r;
    n.s1 = async_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  // only the second and third stages are compared
  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;
endmodule

// [verilog/vot_pkg.sv]
// constants, field layouts and state codes of the overlay timing sequencer
// Function
// - timing memory is two banks of 64 32-bit words; idle bank rewritable.
// - field select 11 picks remote video, 00 picks own graphics.
// - graphics selected only during active data, remote source otherwise.
// - programmed line is one pixel clock shorter than nominal line.
// - vertical pair holds 00 in first field, 11 in second field.
// - per field, 200 remote lines then 40 graphics lines.
// - line is 235 blank, 8 sync, 1440 data with strobe, 31 closing.
// - config 0x2042 gives rising-edge launch, active-high data, controller on.
// - pixel clock comes from the external clock input so it can be gated.
// - end-of-frame and error interrupts disabled, request level zero.
// - event report shows bus fault, underrun, end of frame; needs no setup.
// - command 0x00 picks bank 0, fifo set 0, frame-buffer image shown.
// - background colour 0x80108010 shows black in luma/chroma format.
// - frame config 0x0780505A: interlaced, 240 lines, gap 90, 90 bursts.
// - set 0 fetches odd field from base A, even field from base B.
// - only set 0 used; set 1 registers stay at defaults.
// - vertical output programmed as a field indication.
package vot_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_EVENT = 12'h004;
  localparam logic [11:0] OFF_CMD = 12'h008;
  localparam logic [11:0] OFF_BG = 12'h00C;
  localparam logic [11:0] OFF_FC0 = 12'h010;
  localparam logic [11:0] OFF_FA0 = 12'h014;
  localparam logic [11:0] OFF_FB0 = 12'h018;
  localparam logic [11:0] OFF_FC1 = 12'h01C;
  localparam logic [11:0] OFF_FA1 = 12'h020;
  localparam logic [11:0] OFF_FB1 = 12'h024;
  localparam logic [1:0] RAM_AREA = 2'h1;
  localparam int RAM_BANK_BIT = 8;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CFG_ON = 1;
  localparam int CFG_EOF_IE = 3;
  localparam int CFG_ERR_IE = 4;
  localparam int CFG_FALL_EDGE = 5;
  localparam int CFG_EXT_CLK = 6;
  localparam int CFG_DATA_LOW = 7;
  localparam int EVT_BUS_FAULT = 0;
  localparam int EVT_UNDERRUN = 1;
  localparam int EVT_EOF = 2;
  localparam int EVT_BANK = 8;
  localparam int CMD_BANK = 0;
  localparam int CMD_FIFO = 1;
  localparam int CMD_BLANK = 2;
  localparam int W_HS = 0;
  localparam int W_VX = 2;
  localparam int W_FX = 4;
  localparam int W_BX = 6;
  localparam int W_DS = 8;
  localparam int W_CNT = 11;
  localparam int W_LOOP = 23;
  localparam int W_LAST = 24;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ------------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] SEL_REMOTE = 2'h3;
  localparam logic [1:0] SEL_GFX = 2'h0;
  localparam logic [1:0] PAIR_IDLE = 2'h0;
  localparam logic [31:0] RST_REG = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_DRIVE = 3'b100
  } vot_seq_t;

endpackage

// [verilog/vot_timing_seq.sv]
// video timing sequencer with double-banked timing memory and ahb-lite slave
`timescale 1ns/1ps
module vot_timing_seq #(
  parameter int DEPTH = 64,
  parameter int CNT_W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pixel_clk_in,
  input wire logic fifo_underrun,
  input wire logic bus_fault,
  output logic [1:0] line_sync_out,
  output logic [1:0] vertical_out,
  output logic [1:0] field_select_out,
  output logic [1:0] blank_out,
  output logic [1:0] data_strobe_ctl,
  output logic frame_end,
  output logic [31:0] fetch_base_out,
  output logic [31:0] background_out
);
  import vot_pkg::*;

  localparam int IW = $clog2(DEPTH);

  typedef struct packed {
    logic ready;
    logic resp;
    logic [31:0] rdata;
    logic wr_pend;
    logic rd_pend;
    logic [11:0] addr;
    logic [31:0] cfg;
    logic [2:0] evt;
    logic [2:0] cmd;
    logic [31:0] bg;
    logic [31:0] fc0;
    logic [31:0] fa0;
    logic [31:0] fb0;
    logic [31:0] fc1;
    logic [31:0] fa1;
    logic [31:0] fb1;
    vot_seq_t st;
    logic bank;
    logic [IW-1:0] idx;
    logic [IW-1:0] lstart;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rem;
    logic lopen;
    logic cur_loop;
    logic cur_last;
    logic [1:0] hs;
    logic [1:0] vx;
    logic [1:0] fx;
    logic [1:0] bx;
    logic [1:0] ds;
    logic fend;
    logic [31:0] base;
  } vot_regs_t;

  vot_regs_t r;
  vot_regs_t n;

  // both banks in one array; the bank bit is the index msb
  logic [31:0] mem [2*DEPTH];
  logic ram_we;
  logic [IW:0] ram_waddr;
  logic [31:0] word;
  logic [CNT_W-1:0] wcnt;
  logic prise;
  logic pfall;
  logic on;
  logic tick;
  logic fin;
  logic acc;
  logic in_ram;

  // ------------------------------------------------------------------
  // pixel clock edges
  // ------------------------------------------------------------------
  vot_edge_sync u_pix (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in(pixel_clk_in),
    .rise(prise),
    .fall(pfall)
  );

  assign word = mem[{r.bank, r.idx}];
  assign wcnt = word[W_CNT +: CNT_W];
  assign on = r.cfg[CFG_ON];
  assign in_ram = (r.addr[11:10] == RAM_AREA);

  always_comb begin
    n = r;
    fin = 1'b0;
    ram_we = 1'b0;
    ram_waddr = {r.addr[RAM_BANK_BIT], r.addr[IW+1:2]};
    n.fend = 1'b0;
    n.ready = 1'b1;
    n.resp = 1'b0;
    n.wr_pend = 1'b0;
    n.rd_pend = 1'b0;
    // internal source ticks every cycle; the gated outside clock is normal
    if (r.cfg[CFG_EXT_CLK]) begin
      tick = r.cfg[CFG_FALL_EDGE] ? pfall : prise;
    end else begin
      tick = 1'b1;
    end

    // ----------------------------------------------------------------
    // bus address phase
    // ----------------------------------------------------------------
    acc = hsel & htrans[1] & hready;
    if (acc) begin
      n.addr = haddr[11:0];
      if (hwrite) begin
        n.wr_pend = (hsize == HSIZE_WORD);
      end else begin
        n.rd_pend = 1'b1;
        n.ready = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // bus data phase: writes
    // ----------------------------------------------------------------
    if (r.wr_pend) begin
      if (in_ram) begin
        // the bank driving the outputs is refused while running
        ram_we = (r.addr[RAM_BANK_BIT] != r.bank) || (r.st == ST_IDLE);
      end else begin
        case (r.addr)
          OFF_CONFIG: n.cfg = hwdata;
          OFF_EVENT: n.evt = r.evt & ~hwdata[2:0];
          OFF_CMD: n.cmd = hwdata[2:0];
          OFF_BG: n.bg = hwdata;
          OFF_FC0: n.fc0 = hwdata;
          OFF_FA0: n.fa0 = hwdata;
          OFF_FB0: n.fb0 = hwdata;
          OFF_FC1: n.fc1 = hwdata;
          OFF_FA1: n.fa1 = hwdata;
          OFF_FB1: n.fb1 = hwdata;
          default: n.cfg = r.cfg;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // bus data phase: reads, one wait state so writes land first
    // ----------------------------------------------------------------
    if (r.rd_pend) begin
      n.rdata = RST_REG;
      if (in_ram) begin
        n.rdata = mem[{r.addr[RAM_BANK_BIT], r.addr[IW+1:2]}];
      end else begin
        case (r.addr)
          OFF_CONFIG: n.rdata = r.cfg;
          OFF_EVENT: begin
            n.rdata[2:0] = r.evt;
            n.rdata[EVT_BANK] = r.bank;
          end
          OFF_CMD: n.rdata[2:0] = r.cmd;
          OFF_BG: n.rdata = r.bg;
          OFF_FC0: n.rdata = r.fc0;
          OFF_FA0: n.rdata = r.fa0;
          OFF_FB0: n.rdata = r.fb0;
          OFF_FC1: n.rdata = r.fc1;
          OFF_FA1: n.rdata = r.fa1;
          OFF_FB1: n.rdata = r.fb1;
          default: n.rdata = RST_REG;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    case (r.st)
      ST_IDLE: begin
        if (on) begin
          n.st = ST_FETCH;
          n.idx = '0;
          n.bank = r.cmd[CMD_BANK];
          n.lopen = 1'b0;
        end
      end
      ST_FETCH: begin
        if (word[W_LOOP] && !r.lopen) begin
          // loop start costs no outside pixel clock, but one tick of the internal source; its count is the repeat count
          n.lopen = 1'b1;
          n.rem = wcnt;
          n.idx = r.idx + 1'b1;
          n.lstart = r.idx + 1'b1;
        end else if (tick) begin
          n.hs = word[W_HS +: 2];
          n.vx = word[W_VX +: 2];
          n.bx = word[W_BX +: 2];
          if (r.cmd[CMD_BLANK]) begin
            n.fx = SEL_REMOTE;
            n.ds = PAIR_IDLE;
          end else begin
            n.fx = word[W_FX +: 2];
            n.ds = word[W_DS +: 2] ^ {2{r.cfg[CFG_DATA_LOW]}};
          end
          n.cur_loop = word[W_LOOP];
          n.cur_last = word[W_LAST];
          // an entry with a nonzero count lasts exactly its count, so short lines stay short
          n.cnt = (wcnt == '0) ? '0 : wcnt - 1'b1;
          n.st = ST_DRIVE;
          fin = (n.cnt == '0);
        end
      end
      ST_DRIVE: begin
        if (tick) begin
          n.cnt = r.cnt - 1'b1;
          fin = (r.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
        end
      end
      default: n.st = ST_IDLE;
    endcase

    if (fin) begin
      n.st = ST_FETCH;
      if (n.cur_loop && r.lopen && r.rem > {{(CNT_W-1){1'b0}}, 1'b1}) begin
        n.rem = r.rem - 1'b1;
        n.idx = r.lstart;
      end else begin
        if (n.cur_loop) begin
          n.lopen = 1'b0;
        end
        if (n.cur_last) begin
          n.idx = '0;
          n.bank = r.cmd[CMD_BANK];
          n.fend = 1'b1;
        end else begin
          n.idx = r.idx + 1'b1;
        end
      end
    end

    if (!on) begin
      n.st = ST_IDLE;
      n.idx = '0;
      n.hs = PAIR_IDLE;
      n.vx = PAIR_IDLE;
      n.fx = SEL_REMOTE;
      n.bx = PAIR_IDLE;
      n.ds = PAIR_IDLE;
    end

    // events set after the clear, so a same-cycle event survives
    if (n.fend) begin
      n.evt[EVT_EOF] = 1'b1;
    end
    if (fifo_underrun) begin
      n.evt[EVT_UNDERRUN] = 1'b1;
    end
    if (bus_fault) begin
      n.evt[EVT_BUS_FAULT] = 1'b1;
    end

    // ----------------------------------------------------------------
    // fetch base follows the field now on the vertical pair
    // ----------------------------------------------------------------
    if (r.cmd[CMD_FIFO]) begin
      n.base = (r.vx == SEL_REMOTE) ? r.fb1 : r.fa1;
    end else begin
      n.base = (r.vx == SEL_REMOTE) ? r.fb0 : r.fa0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.ready <= 1'b1;
      r.st <= ST_IDLE;
      r.fx <= SEL_REMOTE;
    end else if (ce) begin
      r <= n;
    end
  end

  // memory content survives reset on purpose: software loads it once
  always_ff @(posedge clk) begin
    if (ce && ram_we && !reset) begin
      mem[ram_waddr] <= hwdata;
    end
  end

  assign hreadyout = r.ready;
  assign hresp = r.resp;
  assign hrdata = r.rdata;
  assign line_sync_out = r.hs;
  assign vertical_out = r.vx;
  assign field_select_out = r.fx;
  assign blank_out = r.bx;
  assign data_strobe_ctl = r.ds;
  assign frame_end = r.fend;
  assign fetch_base_out = r.base;
  assign background_out = r.bg;
endmodule
